// ### hw/autobaud_pkg.sv
// shared constants, types and state encoding for the autobaud detector
package autobaud_pkg;

	// ----------------------------------------------------------------
	// widths and fixed values
	// ----------------------------------------------------------------
	localparam int DIV_W = 16;
	localparam int PRE_W = 10;
	localparam int PHASE_W = 7;
	localparam logic [15:0] DIV_MAX = 16'hFFFF;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [2:0] EDGE_FIRST = 3'h1;
	localparam logic [2:0] EDGE_BEFORE_LAST = 3'h4;
	localparam int OVF_BIT = 7;

	// ----------------------------------------------------------------
	// measurement counter clock: oscillator divided by these counts
	// ----------------------------------------------------------------
	localparam logic [9:0] PRE_DIV_00 = 10'h200;
	localparam logic [9:0] PRE_DIV_01 = 10'h080;
	localparam logic [9:0] PRE_DIV_10 = 10'h080;
	localparam logic [9:0] PRE_DIV_11 = 10'h020;

	// ----------------------------------------------------------------
	// sample ticks per bit in normal running
	// ----------------------------------------------------------------
	localparam logic [6:0] OVS_00 = 7'h40;
	localparam logic [6:0] OVS_01 = 7'h10;
	localparam logic [6:0] OVS_10 = 7'h10;
	localparam logic [6:0] OVS_11 = 7'h04;

	typedef struct packed {
		logic async_mode;
		logic wake_on_break_enable;
		logic divider_16bit_select;
		logic high_speed_select;
	} ab_cfg_s;

	typedef struct packed {
		logic autobaud_enable;
		logic autobaud_overflow;
		logic receive_complete_flag;
		logic autobaud_measure_mode;
	} ab_status_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_BREAK,
		ST_WAIT_START,
		ST_WAIT_RISE1,
		ST_COUNT
	} ab_state_e;

	function automatic logic [9:0] pre_period(input logic b16, input logic hs);
		case ({b16, hs})
			2'b00: pre_period = PRE_DIV_00;
			2'b01: pre_period = PRE_DIV_01;
			2'b10: pre_period = PRE_DIV_10;
			default: pre_period = PRE_DIV_11;
		endcase
	endfunction

	function automatic logic [6:0] ovs_count(input logic b16, input logic hs);
		case ({b16, hs})
			2'b00: ovs_count = OVS_00;
			2'b01: ovs_count = OVS_01;
			2'b10: ovs_count = OVS_10;
			default: ovs_count = OVS_11;
		endcase
	endfunction

endpackage

// ### hw/autobaud_prescaler.sv
// measurement counter clock prescaler, restartable
`timescale 1ns/1ps
module autobaud_prescaler (
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_clear, // hold at zero
	input wire logic [autobaud_pkg::PRE_W-1:0] i_period, // tick period in clocks
	output logic o_tick // one-cycle tick
);
	import autobaud_pkg::*;

	logic [PRE_W-1:0] cnt_r;
	logic [PRE_W-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb begin
		cnt_nxt = cnt_r + 1'b1;
		tick_nxt = 1'b0;
		if (i_clear) begin
			cnt_nxt = '0;
		end else if (cnt_r == i_period - 1'b1) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

endmodule // autobaud_prescaler

// ### hw/uart_autobaud_detect.sv
// autobaud measurement and baud generator for the enhanced serial port
`timescale 1ns/1ps
module uart_autobaud_detect #(
	parameter int DIV_WIDTH = autobaud_pkg::DIV_W // divisor width
) (
	input wire logic i_core_clk, // core clock, 40 MHz
	input wire logic i_rst_n, // async reset, active low
	input wire autobaud_pkg::ab_cfg_s i_cfg, // mode and divider selects
	input wire logic i_serial_receive_input, // receive pin level
	input wire logic i_break_done, // pulse: wake logic saw the break
	input wire logic i_autobaud_enable_wr, // pulse: write enable bit
	input wire logic i_autobaud_enable_wdata, // value for enable bit
	input wire logic i_overflow_wr, // pulse: write overflow bit
	input wire logic i_overflow_wdata, // value for overflow bit
	input wire logic i_divisor_wr, // pulse: write divisor pair
	input wire logic [autobaud_pkg::DIV_W-1:0] i_divisor_wdata, // divisor value
	input wire logic i_receive_buffer_rd, // pulse: receive buffer read
	input wire logic i_transmit_buffer_wr, // pulse: transmit buffer write
	output autobaud_pkg::ab_status_s o_status, // status bits
	output logic [autobaud_pkg::DIV_W-1:0] o_divisor, // divisor pair
	output logic o_tx_write_accept, // pulse: transmit write taken
	output logic o_sample_tick, // pulse: sampling clock
	output logic o_bit_tick // pulse: one bit time
);
	import autobaud_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (DIV_WIDTH != DIV_W) begin : g_bad_width
		$error("divisor width must be 16");
	end

	// ----------------------------------------------------------------
	// measurement state
	// ----------------------------------------------------------------
	ab_state_e state_r, state_nxt;
	logic en_r, en_nxt;
	logic ovf_r, ovf_nxt;
	logic rcf_r, rcf_nxt;
	logic mode_r, mode_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic [2:0] edges_r, edges_nxt;
	logic rx_prev_r;
	logic tx_acc_r, tx_acc_nxt;
	logic rise;
	logic fall;
	logic pre_tick;
	logic pre_clear;
	logic [PRE_W-1:0] pre_per;

	assign rise = i_serial_receive_input & ~rx_prev_r;
	assign fall = ~i_serial_receive_input & rx_prev_r;
	assign pre_per = pre_period(i_cfg.divider_16bit_select, i_cfg.high_speed_select);
	assign pre_clear = (state_r != ST_COUNT);

	autobaud_prescaler u_pre (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_clear(pre_clear),
		.i_period(pre_per),
		.o_tick(pre_tick)
	);

	always_comb begin
		state_nxt = state_r;
		en_nxt = en_r;
		ovf_nxt = ovf_r;
		rcf_nxt = rcf_r;
		div_nxt = div_r;
		edges_nxt = edges_r;
		tx_acc_nxt = i_transmit_buffer_wr & ~en_r;
		if (i_overflow_wr) begin
			ovf_nxt = i_overflow_wdata;
		end
		if (i_receive_buffer_rd) begin
			rcf_nxt = 1'b0;
		end
		if (i_divisor_wr && !en_r) begin
			div_nxt = i_divisor_wdata;
		end
		case (state_r)
			ST_IDLE: begin
				if (en_r && i_cfg.async_mode) begin
					state_nxt = i_cfg.wake_on_break_enable ? ST_WAIT_BREAK : ST_WAIT_START;
				end
			end
			ST_WAIT_BREAK: begin
				if (i_break_done) begin
					state_nxt = ST_WAIT_START;
				end
			end
			ST_WAIT_START: begin
				if (fall) begin
					state_nxt = ST_WAIT_RISE1;
				end
			end
			ST_WAIT_RISE1: begin
				if (rise) begin
					state_nxt = ST_COUNT;
					edges_nxt = EDGE_FIRST;
				end
			end
			ST_COUNT: begin
				if (pre_tick) begin
					// full 16-bit count whatever the divider select
					div_nxt = div_r + 1'b1;
					if (div_r == DIV_MAX) begin
						ovf_nxt = 1'b1;
					end
				end
				if (rise) begin
					if (edges_r == EDGE_BEFORE_LAST) begin
						en_nxt = 1'b0;
						rcf_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end else begin
						edges_nxt = edges_r + 1'b1;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (!i_cfg.async_mode || !en_r) begin
			state_nxt = ST_IDLE;
		end
		if (i_autobaud_enable_wr) begin
			en_nxt = i_autobaud_enable_wdata;
			if (i_autobaud_enable_wdata && !en_r) begin
				div_nxt = DIV_RESET;
				state_nxt = ST_IDLE;
			end else if (!i_autobaud_enable_wdata) begin
				state_nxt = ST_IDLE;
			end
		end
		mode_nxt = (state_nxt != ST_IDLE);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
			en_r <= 1'b0;
			ovf_r <= 1'b0;
			rcf_r <= 1'b0;
			mode_r <= 1'b0;
			div_r <= DIV_RESET;
			edges_r <= '0;
			rx_prev_r <= 1'b1;
			tx_acc_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			en_r <= en_nxt;
			ovf_r <= ovf_nxt;
			rcf_r <= rcf_nxt;
			mode_r <= mode_nxt;
			div_r <= div_nxt;
			edges_r <= edges_nxt;
			rx_prev_r <= i_serial_receive_input;
			tx_acc_r <= tx_acc_nxt;
		end
	end

	// ----------------------------------------------------------------
	// baud generator in normal running
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] smp_cnt_r, smp_cnt_nxt;
	logic [PHASE_W-1:0] phase_r, phase_nxt;
	logic smp_r, smp_nxt;
	logic bit_r, bit_nxt;
	logic [DIV_W-1:0] div_eff;
	logic [PHASE_W-1:0] ovs;

	assign div_eff = i_cfg.divider_16bit_select ? div_r : {8'h00, div_r[7:0]};
	assign ovs = ovs_count(i_cfg.divider_16bit_select, i_cfg.high_speed_select);

	always_comb begin
		smp_cnt_nxt = smp_cnt_r + 1'b1;
		phase_nxt = phase_r;
		smp_nxt = 1'b0;
		bit_nxt = 1'b0;
		if (mode_r) begin
			// generator is taken over by the measurement
			smp_cnt_nxt = '0;
			phase_nxt = '0;
		end else if (smp_cnt_r >= div_eff) begin
			smp_cnt_nxt = '0;
			smp_nxt = 1'b1;
			if (phase_r >= ovs - 1'b1) begin
				phase_nxt = '0;
				bit_nxt = 1'b1;
			end else begin
				phase_nxt = phase_r + 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			smp_cnt_r <= '0;
			phase_r <= '0;
			smp_r <= 1'b0;
			bit_r <= 1'b0;
		end else begin
			smp_cnt_r <= smp_cnt_nxt;
			phase_r <= phase_nxt;
			smp_r <= smp_nxt;
			bit_r <= bit_nxt;
		end
	end

	assign o_status = '{autobaud_enable: en_r, autobaud_overflow: ovf_r,
		receive_complete_flag: rcf_r, autobaud_measure_mode: mode_r};
	assign o_divisor = div_r;
	assign o_tx_write_accept = tx_acc_r;
	assign o_sample_tick = smp_r;
	assign o_bit_tick = bit_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic keep;
	logic [PRE_W-1:0] gap_r;
	logic gap_ok_r;

	assign keep = en_r & i_cfg.async_mode & ~i_autobaud_enable_wr;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_r <= '0;
			gap_ok_r <= 1'b0;
		end else if (pre_clear) begin
			gap_r <= '0;
			gap_ok_r <= 1'b0;
		end else if (pre_tick) begin
			gap_r <= '0;
			gap_ok_r <= 1'b1;
		end else begin
			gap_r <= gap_r + 1'b1;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	AST_SYNC_OFF: assert property (!i_cfg.async_mode |=> !o_status.autobaud_measure_mode)
		else $error("measurement active outside async mode");
	AST_START_BIT: assert property (state_r == ST_WAIT_START && fall && keep |=> state_r == ST_WAIT_RISE1)
		else $error("start bit did not start the sequence");
	AST_ENABLE_CLEARS: assert property (i_autobaud_enable_wr && i_autobaud_enable_wdata && !en_r
		|=> o_divisor == DIV_RESET && o_status.autobaud_enable)
		else $error("enable did not clear the divisor");
	AST_FIRST_RISE: assert property (state_r == ST_WAIT_RISE1 && rise && keep
		|=> state_r == ST_COUNT && edges_r == EDGE_FIRST)
		else $error("counting did not begin at the first rise");
	AST_FIFTH_RISE: assert property (state_r == ST_COUNT && rise && edges_r == EDGE_BEFORE_LAST && keep
		|=> !o_status.autobaud_enable && o_status.receive_complete_flag && !o_status.autobaud_measure_mode)
		else $error("fifth rise did not end the measurement");
	AST_WRAP_FLAG: assert property (state_r == ST_COUNT && pre_tick && div_r == DIV_MAX && keep
		|=> o_status.autobaud_overflow && o_divisor == DIV_RESET)
		else $error("wrap not trapped in overflow bit");
	AST_WRAP_STAYS: assert property (state_r == ST_COUNT && pre_tick && div_r == DIV_MAX && keep && !rise
		|=> o_status.autobaud_enable && o_status.autobaud_measure_mode)
		else $error("wrap stopped the measurement");
	AST_OVF_WRITE: assert property (i_overflow_wr && !(state_r == ST_COUNT && pre_tick)
		|=> o_status.autobaud_overflow == $past(i_overflow_wdata))
		else $error("overflow bit ignored a write");
	AST_TICK_RATE: assert property (pre_tick && gap_ok_r |-> gap_r == pre_per - 1'b1)
		else $error("measurement tick spacing wrong");
	AST_FULL_WIDTH: assert property (state_r == ST_COUNT && pre_tick && div_r == 16'h00FF && keep
		|=> o_divisor == 16'h0100)
		else $error("carry did not reach high byte");
	AST_RCF_READ: assert property (i_receive_buffer_rd && !(state_r == ST_COUNT && rise)
		|=> !o_status.receive_complete_flag)
		else $error("read did not clear receive flag");
	AST_BREAK_WAIT: assert property (state_r == ST_WAIT_BREAK && !i_break_done && keep
		|=> state_r == ST_WAIT_BREAK)
		else $error("measurement began before the break");
	AST_TX_LOCK: assert property (i_transmit_buffer_wr && en_r |=> !o_tx_write_accept)
		else $error("transmit write taken while enabled");
	AST_RX_HELD: assert property (state_r == ST_COUNT |-> $past(state_r) != ST_IDLE && o_status.autobaud_measure_mode)
		else $error("receiver not held idle");

	COV_DONE: cover property (state_r == ST_COUNT && rise && edges_r == EDGE_BEFORE_LAST);
	COV_WRAP: cover property (state_r == ST_COUNT && pre_tick && div_r == DIV_MAX);
	COV_BREAK: cover property (state_r == ST_WAIT_BREAK && i_break_done);
	COV_BIT: cover property (o_bit_tick);

endmodule // uart_autobaud_detect

// ### sim/autobaud_remote_tx.sv
// far-end serial transmitter that sends calibration bytes and breaks
`timescale 1ns/1ps
module autobaud_remote_tx (
	input wire logic i_core_clk, // bench clock
	output logic o_line // serial line, idle high
);
	initial o_line = 1'b1;

	// one level for bclk clocks, changed at the falling edge
	task automatic hold_bit(input logic v, input int bclk);
		@(negedge i_core_clk);
		o_line = v;
		repeat (bclk - 1) @(negedge i_core_clk);
	endtask

	// start bit, eight data bits lsb first, stop bit left idle high
	task automatic send_byte(input logic [7:0] b, input int bclk);
		hold_bit(1'b0, bclk);
		for (int i = 0; i < 8; i++) begin
			hold_bit(b[i], bclk);
		end
		hold_bit(1'b1, bclk);
	endtask
endmodule // autobaud_remote_tx

// ### sim/uart_autobaud_detect_bench.sv
// self-checking bench for the autobaud detector
`timescale 1ns/1ps
module uart_autobaud_detect_bench;
	import autobaud_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	ab_cfg_s cfg = 4'h8;
	logic rx;
	logic brk = 1'b0;
	logic en_wr = 1'b0;
	logic en_d = 1'b0;
	logic ov_wr = 1'b0;
	logic ov_d = 1'b0;
	logic dv_wr = 1'b0;
	logic [15:0] dv_d = 16'h0000;
	logic rd = 1'b0;
	logic tx_wr = 1'b0;
	ab_status_s st;
	logic [15:0] dv;
	logic acc;
	logic s_tick;
	logic b_tick;
	int errors = 0;
	int total_checks = 0;

	always #12.5 clk = ~clk;

	uart_autobaud_detect u_uart_autobaud_detect (
		.i_core_clk(clk),
		.i_rst_n(rst_n),
		.i_cfg(cfg),
		.i_serial_receive_input(rx),
		.i_break_done(brk),
		.i_autobaud_enable_wr(en_wr),
		.i_autobaud_enable_wdata(en_d),
		.i_overflow_wr(ov_wr),
		.i_overflow_wdata(ov_d),
		.i_divisor_wr(dv_wr),
		.i_divisor_wdata(dv_d),
		.i_receive_buffer_rd(rd),
		.i_transmit_buffer_wr(tx_wr),
		.o_status(st),
		.o_divisor(dv),
		.o_tx_write_accept(acc),
		.o_sample_tick(s_tick),
		.o_bit_tick(b_tick)
	);

	autobaud_remote_tx u_autobaud_remote_tx (
		.i_core_clk(clk),
		.o_line(rx)
	);

	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one software write pulse: 0 enable, 1 overflow, 2 divisor, 3 read, 4 transmit, else break seen
	task automatic sw(input int w, input logic [15:0] v);
		@(negedge clk);
		case (w)
			0: en_wr = 1'b1;
			1: ov_wr = 1'b1;
			2: dv_wr = 1'b1;
			3: rd = 1'b1;
			4: tx_wr = 1'b1;
			default: brk = 1'b1;
		endcase
		en_d = v[0];
		ov_d = v[0];
		dv_d = v;
		@(negedge clk);
		{en_wr, ov_wr, dv_wr, rd, tx_wr, brk} = 6'h00;
	endtask

	task automatic tx_try(input logic e);
		logic a;
		sw(4, 16'h0000);
		a = acc;
		@(negedge clk);
		check(a | acc, e);
	endtask

	task automatic wait_flag();
		int k;
		k = 0;
		while (st.receive_complete_flag !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		check(st.receive_complete_flag, 1'b1);
		if (k >= 100) end_of_test();
	endtask

	// one count of slack for the prescaler phase at the first rise
	task automatic chk_div(input logic [15:0] e);
		check((dv + 16'h0001 == e || dv - 16'h0001 == e) ? e : dv, e);
		check(dv[15:8], e[15:8]);
	endtask

	task automatic gap(input logic bt, output int n);
		int k;
		k = 0;
		n = 0;
		while ((bt ? b_tick : s_tick) !== 1'b1 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		do begin
			@(negedge clk);
			n++;
		end while ((bt ? b_tick : s_tick) !== 1'b1 && n < 2000);
		check(k < 2000, 1'b1);
		if (k >= 2000) end_of_test();
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic measure(input logic [1:0] sel, input int b, input logic [15:0] e);
		{cfg.divider_16bit_select, cfg.high_speed_select} = sel;
		sw(2, 16'h1234);
		check(dv, 16'h1234);
		sw(0, 16'h0001);
		sw(2, 16'h4321);
		tx_try(1'b0);
		check(dv, 16'h0000);
		check(st.autobaud_measure_mode, 1'b1);
		u_autobaud_remote_tx.send_byte(8'h55, b);
		wait_flag();
		chk_div(e);
		check(st.autobaud_enable, 1'b0);
		check(st.autobaud_measure_mode, 1'b0);
		sw(3, 16'h0000);
		@(negedge clk);
		check(st.receive_complete_flag, 1'b0);
		$display("done measure %h", sel);
	endtask

	task automatic no_measure();
		cfg.async_mode = 1'b0;
		sw(0, 16'h0001);
		u_autobaud_remote_tx.send_byte(8'h55, 80);
		check(st.receive_complete_flag, 1'b0);
		check(st.autobaud_measure_mode, 1'b0);
		sw(0, 16'h0000);
		cfg.async_mode = 1'b1;
		$display("done no_measure");
	endtask

	task automatic wake_path();
		cfg = 4'hf;
		sw(0, 16'h0001);
		u_autobaud_remote_tx.hold_bit(1'b0, 1040);
		u_autobaud_remote_tx.hold_bit(1'b1, 80);
		check(st.receive_complete_flag, 1'b0);
		check(st.autobaud_measure_mode, 1'b1);
		sw(5, 16'h0000);
		u_autobaud_remote_tx.send_byte(8'h55, 80);
		wait_flag();
		chk_div(16'h0014);
		sw(3, 16'h0000);
		cfg.wake_on_break_enable = 1'b0;
		$display("done wake_path");
	endtask

	task automatic ovf_rw();
		sw(1, 16'h0001);
		@(negedge clk);
		check(st.autobaud_overflow, 1'b1);
		sw(1, 16'h0000);
		@(negedge clk);
		check(st.autobaud_overflow, 1'b0);
		$display("done ovf_rw");
	endtask

	task automatic baud_gen();
		int n;
		cfg = 4'h8;
		sw(2, 16'h0103);
		gap(1'b0, n);
		check(16'(n), 16'h0004);
		gap(1'b1, n);
		check(16'(n), 16'h0100);
		cfg = 4'h9;
		gap(1'b1, n);
		gap(1'b1, n);
		check(16'(n), 16'h0040);
		cfg = 4'hb;
		gap(1'b1, n);
		gap(1'b1, n);
		check(16'(n), 16'h0410);
		$display("done baud_gen");
	endtask

	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		check(16'(st), 16'h0000);
		check(dv, 16'h0000);
		// a transmit write is taken while the enable bit is clear
		tx_try(1'b1);
		measure(2'h3, 80, 16'h0014);
		measure(2'h2, 320, 16'h0014);
		measure(2'h0, 1280, 16'h0014);
		measure(2'h1, 4160, 16'h0104);
		no_measure();
		wake_path();
		ovf_rw();
		baud_gen();
		end_of_test();
	end
endmodule // uart_autobaud_detect_bench
